// *** logic/mls_loopback_select.sv ***
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

module mls_loopback_select (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mls_pkg::mls_modem_in_t modem_pins,
  input wire logic loop_request,
  input wire logic request_flop_q,
  input wire logic terminal_ready_flop_n,
  input wire logic run_flag,
  input wire logic half_duplex_flag,
  input wire logic tx_serial_data,
  input wire logic single_step_clk,
  output logic transmitter_enable,
  output logic request_to_send_out,
  output logic terminal_ready_out,
  output logic receiver_serial_in,
  output logic external_clock_out,
  output logic maint_square_clock,
  output logic tx_clock,
  output logic rx_clock
);

  mls_pkg::mls_state_t q;
  mls_pkg::mls_state_t next_q;

  logic dataset_ready_status;
  logic clear_to_send_status;
  logic call_alert_status;
  logic modem_send_permit;
  logic maint_mode;
  logic user_send;
  logic modem_rx_serial;
  logic modem_tx_clk;
  logic modem_rx_clk;
  logic rx_clk_base;
  logic apb_setup;
  logic apb_write;
  mls_pkg::mls_clock_source_mux_t clock_source_mux;

  // ----------------------------------------
  // modem status and mode decode
  // ----------------------------------------
  always_comb
  begin
    // the strap sits ahead of both status and permit, unlike the request-to-send output
    dataset_ready_status = q.cfg.dsr_force_strap | q.s2.dsr;
    clear_to_send_status = q.s2.cts;
    call_alert_status = q.s2.ring;
    modem_send_permit = dataset_ready_status & clear_to_send_status;
    maint_mode = loop_request | q.icr_maintenance_bit;
    // high-speed unit has no level converters, so the integral modem decides
    if (q.cfg.hs_variant)
    begin
      user_send = ~q.s2.cts_int_n;
    end
    else
    begin
      user_send = modem_send_permit;
    end
    // switch closed picks differential; single-ended arrives inverted
    if (q.cfg.iface_diff_sel)
    begin
      modem_tx_clk = q.s2.txc_diff;
      modem_rx_serial = q.s2.rxd_diff;
      modem_rx_clk = q.s2.rxc_diff;
    end
    else
    begin
      modem_tx_clk = ~q.s2.txc_se;
      modem_rx_serial = ~q.s2.rxd_se;
      modem_rx_clk = ~q.s2.rxc_se;
    end
    clock_source_mux = mls_pkg::mls_clock_source_mux_t'({run_flag, maint_mode});
    apb_setup = psel & ~penable;
    apb_write = psel & penable & pwrite;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_q = q;
    // pins pass two flops before anything looks at them
    next_q.s1 = modem_pins;
    next_q.s2 = q.s1;
    // oscillator divider has no enable: it toggles on every rising edge
    next_q.osc_prev = q.s2.rc_osc;
    if (q.s2.rc_osc & ~q.osc_prev)
    begin
      next_q.rc_divider_flop = ~q.rc_divider_flop;
    end

    // transmitter is only ever enabled through this mux
    if (maint_mode)
    begin
      next_q.transmitter_enable = request_flop_q;
      next_q.receiver_serial_in = tx_serial_data;
    end
    else
    begin
      next_q.transmitter_enable = user_send;
      next_q.receiver_serial_in = modem_rx_serial;
    end
    // force strap sits after the mux, so it also wins in maintenance
    next_q.request_to_send_out = q.cfg.rts_force_strap
      | (~maint_mode & request_flop_q);
    next_q.terminal_ready_out = ~maint_mode & ~terminal_ready_flop_n;
    next_q.external_clock_out = q.cfg.ext_clk_en & q.rc_divider_flop;

    case (clock_source_mux)
      mls_pkg::MLS_SRC_MODEM:
      begin
        next_q.tx_clock = modem_tx_clk;
        rx_clk_base = modem_rx_clk;
      end
      mls_pkg::MLS_SRC_STEP:
      begin
        next_q.tx_clock = single_step_clk;
        rx_clk_base = single_step_clk;
      end
      mls_pkg::MLS_SRC_SIM:
      begin
        // modem clock pins carry the turned-around maintenance clock here
        next_q.tx_clock = modem_tx_clk;
        rx_clk_base = modem_rx_clk;
      end
      mls_pkg::MLS_SRC_MAINT:
      begin
        next_q.tx_clock = q.rc_divider_flop;
        rx_clk_base = q.rc_divider_flop;
      end
      default:
      begin
        next_q.tx_clock = modem_tx_clk;
        rx_clk_base = modem_rx_clk;
      end
    endcase
    next_q.rx_clock = rx_clk_base & ~(request_flop_q & half_duplex_flag);

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    // read data is captured in setup so the access phase needs no wait
    if (apb_setup)
    begin
      next_q.pslverr = 1'b0;
      next_q.prdata = mls_pkg::MLS_ZERO_WORD;
      case (paddr)
        mls_pkg::MLS_CTRL_OFS:
        begin
          next_q.prdata[mls_pkg::MLS_CTRL_MAINT_BIT] = q.icr_maintenance_bit;
        end
        mls_pkg::MLS_CFG_OFS:
        begin
          next_q.prdata[mls_pkg::MLS_CFG_DIFF_BIT] = q.cfg.iface_diff_sel;
          next_q.prdata[mls_pkg::MLS_CFG_EXTCLK_BIT] = q.cfg.ext_clk_en;
          next_q.prdata[mls_pkg::MLS_CFG_DSR_FORCE_BIT] = q.cfg.dsr_force_strap;
          next_q.prdata[mls_pkg::MLS_CFG_RTS_FORCE_BIT] = q.cfg.rts_force_strap;
          next_q.prdata[mls_pkg::MLS_CFG_HS_BIT] = q.cfg.hs_variant;
        end
        mls_pkg::MLS_STAT_OFS:
        begin
          next_q.prdata[mls_pkg::MLS_ST_DSR_BIT] = dataset_ready_status;
          next_q.prdata[mls_pkg::MLS_ST_CTS_BIT] = clear_to_send_status;
          next_q.prdata[mls_pkg::MLS_ST_RING_BIT] = call_alert_status;
          next_q.prdata[mls_pkg::MLS_ST_PERMIT_BIT] = modem_send_permit;
          next_q.prdata[mls_pkg::MLS_ST_TXEN_BIT] = q.transmitter_enable;
          next_q.prdata[mls_pkg::MLS_ST_MAINT_BIT] = maint_mode;
          next_q.prdata[mls_pkg::MLS_ST_MCLK_BIT] = q.rc_divider_flop;
        end
        default:
        begin
          next_q.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_write)
    begin
      case (paddr)
        mls_pkg::MLS_CTRL_OFS:
        begin
          next_q.icr_maintenance_bit = pwdata[mls_pkg::MLS_CTRL_MAINT_BIT];
        end
        mls_pkg::MLS_CFG_OFS:
        begin
          next_q.cfg.iface_diff_sel = pwdata[mls_pkg::MLS_CFG_DIFF_BIT];
          next_q.cfg.ext_clk_en = pwdata[mls_pkg::MLS_CFG_EXTCLK_BIT];
          next_q.cfg.dsr_force_strap = pwdata[mls_pkg::MLS_CFG_DSR_FORCE_BIT];
          next_q.cfg.rts_force_strap = pwdata[mls_pkg::MLS_CFG_RTS_FORCE_BIT];
          next_q.cfg.hs_variant = pwdata[mls_pkg::MLS_CFG_HS_BIT];
        end
        default:
        begin
          next_q.icr_maintenance_bit = q.icr_maintenance_bit;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = q.pslverr & psel & penable;
  assign transmitter_enable = q.transmitter_enable;
  assign request_to_send_out = q.request_to_send_out;
  assign terminal_ready_out = q.terminal_ready_out;
  assign receiver_serial_in = q.receiver_serial_in;
  assign external_clock_out = q.external_clock_out;
  assign maint_square_clock = q.rc_divider_flop;
  assign tx_clock = q.tx_clock;
  assign rx_clock = q.rx_clock;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_status_read;
    apb_setup && paddr == mls_pkg::MLS_STAT_OFS |=>
      prdata[mls_pkg::MLS_ST_DSR_BIT] == $past(q.cfg.dsr_force_strap | q.s2.dsr)
      && prdata[mls_pkg::MLS_ST_RING_BIT] == $past(q.s2.ring);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status bits wrong");

  property p_user_send;
    !maint_mode && !q.cfg.hs_variant |=> transmitter_enable == $past(modem_send_permit);
  endproperty
  a_user_send: assert property (p_user_send) else $error("user enable not permit");

  property p_maint_send;
    maint_mode |=> transmitter_enable == $past(request_flop_q);
  endproperty
  a_maint_send: assert property (p_maint_send) else $error("maint enable wrong");

  property p_hs_send;
    !maint_mode && q.cfg.hs_variant |=> transmitter_enable == !$past(q.s2.cts_int_n);
  endproperty
  a_hs_send: assert property (p_hs_send) else $error("high-speed enable wrong");

  property p_maint_off;
    maint_mode && !q.cfg.rts_force_strap |=> !request_to_send_out && !terminal_ready_out;
  endproperty
  a_maint_off: assert property (p_maint_off) else $error("modem lines not off");

  property p_user_lines;
    !maint_mode |=> terminal_ready_out == !$past(terminal_ready_flop_n)
      && request_to_send_out == ($past(request_flop_q) || $past(q.cfg.rts_force_strap));
  endproperty
  a_user_lines: assert property (p_user_lines) else $error("user lines wrong");

  property p_loop_data;
    maint_mode |=> receiver_serial_in == $past(tx_serial_data);
  endproperty
  a_loop_data: assert property (p_loop_data) else $error("loopback data wrong");

  property p_rx_inhibit;
    request_flop_q && half_duplex_flag |=> !rx_clock;
  endproperty
  a_rx_inhibit: assert property (p_rx_inhibit) else $error("rx clock not inhibited");

  property p_ext_clock;
    !q.cfg.ext_clk_en |=> !external_clock_out;
  endproperty
  a_ext_clock: assert property (p_ext_clock) else $error("external clock not gated");

  sequence s_osc_rise;
    !q.osc_prev && q.s2.rc_osc ##1 q.osc_prev;
  endsequence
  property p_divider;
    s_osc_rise |-> maint_square_clock != $past(maint_square_clock);
  endproperty
  a_divider: assert property (p_divider) else $error("divider missed an edge");

  property p_maint_src;
    run_flag && maint_mode |=> tx_clock == $past(q.rc_divider_flop);
  endproperty
  a_maint_src: assert property (p_maint_src) else $error("clock source wrong");

  property p_status_cts;
    apb_setup && paddr == mls_pkg::MLS_STAT_OFS |=>
      prdata[mls_pkg::MLS_ST_CTS_BIT] == $past(q.s2.cts)
      && prdata[mls_pkg::MLS_ST_PERMIT_BIT] == $past(dataset_ready_status && q.s2.cts);
  endproperty
  a_status_cts: assert property (p_status_cts) else $error("permit bit wrong");

  property p_ctrl_write;
    apb_write && paddr == mls_pkg::MLS_CTRL_OFS |=>
      q.icr_maintenance_bit == $past(pwdata[mls_pkg::MLS_CTRL_MAINT_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_rts_force;
    q.cfg.rts_force_strap |=> request_to_send_out;
  endproperty
  a_rts_force: assert property (p_rts_force) else $error("rts strap not honoured");

  property p_ext_follow;
    q.cfg.ext_clk_en |=> external_clock_out == $past(q.rc_divider_flop);
  endproperty
  a_ext_follow: assert property (p_ext_follow) else $error("ext clock not passed");

  property p_step_src;
    !run_flag && maint_mode |=> tx_clock == $past(single_step_clk);
  endproperty
  a_step_src: assert property (p_step_src) else $error("step clock not selected");

  // any toggle without an oscillator rise would break the symmetric square wave
  property p_divider_hold;
    !(q.s2.rc_osc && !q.osc_prev) |=> $stable(maint_square_clock);
  endproperty
  a_divider_hold: assert property (p_divider_hold) else $error("spurious toggle");

endmodule : mls_loopback_select

// *** logic/mls_pkg.sv ***
package mls_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] MLS_CTRL_OFS = 12'h000;
  localparam logic [11:0] MLS_CFG_OFS = 12'h004;
  localparam logic [11:0] MLS_STAT_OFS = 12'h008;
  localparam int unsigned MLS_ADDR_W = 12;
  localparam int unsigned MLS_DATA_W = 32;

  // control: maintenance request bit sits at bit 5
  localparam int unsigned MLS_CTRL_MAINT_BIT = 5;

  // configuration switches and straps
  localparam int unsigned MLS_CFG_DIFF_BIT = 0;
  localparam int unsigned MLS_CFG_EXTCLK_BIT = 1;
  localparam int unsigned MLS_CFG_DSR_FORCE_BIT = 2;
  localparam int unsigned MLS_CFG_RTS_FORCE_BIT = 3;
  localparam int unsigned MLS_CFG_HS_BIT = 4;

  // status
  localparam int unsigned MLS_ST_DSR_BIT = 0;
  localparam int unsigned MLS_ST_CTS_BIT = 1;
  localparam int unsigned MLS_ST_RING_BIT = 2;
  localparam int unsigned MLS_ST_PERMIT_BIT = 3;
  localparam int unsigned MLS_ST_TXEN_BIT = 4;
  localparam int unsigned MLS_ST_MAINT_BIT = 5;
  localparam int unsigned MLS_ST_MCLK_BIT = 6;

  localparam logic [31:0] MLS_ZERO_WORD = 32'h0000_0000;

  // ----------------------------------------
  // maintenance oscillator
  // ----------------------------------------
  localparam int unsigned MLS_RC_OSC_HZ = 20000;
  localparam int unsigned MLS_MAINT_CLK_HZ = 10000;

  // clock source select code: {run_flag, loop or maintenance}
  typedef enum logic [1:0] {
    MLS_SRC_MODEM = 2'b00,
    MLS_SRC_STEP = 2'b01,
    MLS_SRC_SIM = 2'b10,
    MLS_SRC_MAINT = 2'b11
  } mls_clock_source_mux_t;

  // modem side pins, all asynchronous to clk
  typedef struct packed {
    logic dsr;
    logic cts;
    logic ring;
    logic txc_diff;
    logic txc_se;
    logic rxd_diff;
    logic rxd_se;
    logic rxc_diff;
    logic rxc_se;
    logic cts_int_n;
    logic rc_osc;
  } mls_modem_in_t;

  typedef struct packed {
    logic iface_diff_sel;
    logic ext_clk_en;
    logic dsr_force_strap;
    logic rts_force_strap;
    logic hs_variant;
  } mls_cfg_t;

  typedef struct packed {
    mls_modem_in_t s1;
    mls_modem_in_t s2;
    logic osc_prev;
    logic rc_divider_flop;
    logic icr_maintenance_bit;
    mls_cfg_t cfg;
    logic transmitter_enable;
    logic request_to_send_out;
    logic terminal_ready_out;
    logic receiver_serial_in;
    logic external_clock_out;
    logic tx_clock;
    logic rx_clock;
    logic [31:0] prdata;
    logic pslverr;
  } mls_state_t;

endpackage : mls_pkg

// *** test/mls_modem_model.sv ***
`timescale 1ns/1ps

module mls_modem_model #(
  parameter int HALF = 10
) (
  input wire logic clk,
  input wire logic dsr_on,
  input wire logic cts_on,
  input wire logic ring_on,
  input wire logic cts_int_n,
  input wire logic rxd,
  input wire logic se_skew,
  output mls_pkg::mls_modem_in_t pins
);
  // ----------------------------------------
  // oscillator
  // ----------------------------------------
  // scaled far above the real rate so a run stays short; it never stops
  logic osc = 1'h0;
  int cnt = 0;

  always @(posedge clk)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      osc <= ~osc;
  end

  // single-ended lines arrive inverted; se_skew breaks that pairing on purpose
  always_comb
  begin
    pins.dsr = dsr_on;
    pins.cts = cts_on;
    pins.ring = ring_on;
    pins.txc_diff = osc;
    pins.txc_se = ~osc;
    pins.rxd_diff = rxd;
    pins.rxd_se = ~(rxd ^ se_skew);
    pins.rxc_diff = osc;
    pins.rxc_se = ~osc;
    pins.cts_int_n = cts_int_n;
    pins.rc_osc = osc;
  end
endmodule : mls_modem_model

// *** test/tb_top.sv ***
`timescale 1ns/1ps

module tb_top;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic dsr, cts, ring, ctsn, rxd, skew, lreq, rfq, trn, run, hdx, txd, step;
  logic txen, rts, dtr, rxin, extc, mclk, txc, rxc;
  mls_pkg::mls_modem_in_t pins;
  int err_total = 0;
  int n_tests = 0;
  localparam logic [11:0] CT = mls_pkg::MLS_CTRL_OFS;
  localparam logic [11:0] CF = mls_pkg::MLS_CFG_OFS;
  localparam logic [11:0] ST = mls_pkg::MLS_STAT_OFS;

  mls_modem_model i_mls_modem_model (.clk(clk), .dsr_on(dsr), .cts_on(cts), .ring_on(ring),
    .cts_int_n(ctsn), .rxd(rxd), .se_skew(skew), .pins(pins));

  mls_loopback_select i_mls_loopback_select (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .modem_pins(pins), .loop_request(lreq),
    .request_flop_q(rfq), .terminal_ready_flop_n(trn), .run_flag(run),
    .half_duplex_flag(hdx), .tx_serial_data(txd), .single_step_clk(step),
    .transmitter_enable(txen), .request_to_send_out(rts), .terminal_ready_out(dtr),
    .receiver_serial_in(rxin), .external_clock_out(extc), .maint_square_clock(mclk),
    .tx_clock(txc), .rx_clock(rxc));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1)
    begin
      @(posedge clk);
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // outputs are sampled half a cycle after the edge, once they have settled
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : idle

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    apb(1'h0, CT, 32'h0);
    chk("ctrl_rst", 32'h0, rdat);
    apb(1'h0, CF, 32'h0);
    chk("cfg_rst", 32'h0, rdat);
    apb(1'h1, CT, 32'hffff_ffff);
    apb(1'h0, CT, 32'h0);
    chk("ctrl_rb", 32'h20, rdat);
    chk("slverr_ok", 32'h0, serr);
    apb(1'h1, CF, 32'h1f);
    apb(1'h0, CF, 32'h0);
    chk("cfg_set", 32'h1f, rdat);
    apb(1'h1, CF, 32'hffff_ffe0);
    apb(1'h0, CF, 32'h0);
    chk("cfg_rb", 32'h0, rdat);
    apb(1'h0, 12'h00c, 32'h0);
    chk("unmapped", 32'h1, {rdat[30:0], serr});
    apb(1'h1, CT, 32'h0);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_status;
    logic [2:0] v;
    for (int i = 0; i < 8; i++)
    begin
      v = i[2:0];
      @(posedge clk);
      {ring, cts, dsr} <= v;
      idle(4);
      chk("txen", v[0] & v[1], txen);
      apb(1'h0, ST, 32'h0);
      chk("stat", {27'h0, v[0] & v[1], v[0] & v[1], v}, rdat & 32'h3f);
    end
    apb(1'h1, CF, 32'h4);
    @(posedge clk);
    {ring, cts, dsr} <= 3'h2;
    idle(4);
    apb(1'h0, ST, 32'h0);
    chk("dsr_force", 32'h1b, rdat & 32'h3f);
    apb(1'h1, CF, 32'h0);
    $display("t_status done");
  endtask : t_status

  task automatic t_modes;
    logic mt;
    for (int m = 0; m < 3; m++)
    begin
      mt = (m != 0);
      @(posedge clk);
      // modem data and transmit data differ so the loopback choice is visible
      {lreq, rfq, trn, txd, rxd, dsr, cts} <= {m == 1, 6'h28};
      apb(1'h1, CT, (m == 2) ? 32'h20 : 32'h0);
      idle(2);
      chk("txen", mt, txen);
      chk("rts", !mt, rts);
      chk("dtr", !mt, dtr);
      chk("rxin", mt, rxin);
      apb(1'h0, ST, 32'h0);
      chk("mode", mt, rdat[5]);
      @(posedge clk);
      {rfq, txd, rxd} <= 3'h1;
      // modem data needs two sync flops and the output flop
      idle(4);
      chk("txen_off", 1'h0, txen);
      chk("rts_off", 1'h0, rts);
      chk("rxin2", !mt, rxin);
      apb(1'h1, CT, 32'h0);
    end
    lreq <= 1'h0;
    $display("t_modes done");
  endtask : t_modes

  task automatic t_straps;
    apb(1'h1, CF, 32'h8);
    {lreq, rfq} <= 2'h2;
    idle(2);
    chk("rts_force", 1'h1, rts);
    @(posedge clk);
    {skew, rxd, lreq} <= 3'h6;
    apb(1'h1, CF, 32'h1);
    idle(4);
    chk("rx_diff", 1'h1, rxin);
    apb(1'h1, CF, 32'h0);
    idle(4);
    chk("rx_se", 1'h0, rxin);
    @(posedge clk);
    {dsr, cts, ctsn, skew} <= 4'h0;
    apb(1'h1, CF, 32'h10);
    idle(4);
    chk("hs_on", 1'h1, txen);
    @(posedge clk);
    ctsn <= 1'h1;
    idle(4);
    chk("hs_off", 1'h0, txen);
    @(posedge clk);
    {lreq, rfq} <= 2'h3;
    idle(2);
    chk("hs_maint", 1'h1, txen);
    apb(1'h1, CF, 32'h0);
    $display("t_straps done");
  endtask : t_straps

  // rising edges over a window of whole oscillator periods, seen at falling edges
  task automatic count_rises(output int rc, output int mc, output int ec, output int tc,
    output int xc);
    logic [4:0] p;
    {rc, mc, ec, tc, xc} = 0;
    repeat (400)
    begin
      p = {pins.rc_osc, mclk, extc, txc, rxc};
      @(negedge clk);
      rc += (!p[4] && pins.rc_osc);
      mc += (!p[3] && mclk);
      ec += (!p[2] && extc);
      tc += (!p[1] && txc);
      xc += (!p[0] && rxc);
    end
  endtask : count_rises

  task automatic t_clk;
    int rc, mc, ec, tc, xc;
    @(posedge clk);
    {run, lreq, rfq, hdx, step} <= 5'h0;
    for (int k = 0; k < 2; k++)
    begin
      apb(1'h1, CF, k ? 32'h2 : 32'h0);
      idle(4);
      count_rises(rc, mc, ec, tc, xc);
      chk("div2", 1'h1, mc > 5 && rc >= 2 * mc && rc <= 2 * mc + 2);
      chk("extc", 1'h1, k ? (ec + 1 >= mc && ec <= mc + 1) : (ec == 0));
      chk("modem_txc", rc, tc);
      chk("modem_rxc", rc, xc);
    end
    @(posedge clk);
    run <= 1'h1;
    idle(4);
    count_rises(rc, mc, ec, tc, xc);
    chk("sim_txc", rc, tc);
    @(posedge clk);
    lreq <= 1'h1;
    idle(4);
    count_rises(rc, mc, ec, tc, xc);
    chk("maint_txc", mc, tc);
    chk("maint_rxc", mc, xc);
    @(posedge clk);
    {rfq, hdx} <= 2'h3;
    idle(4);
    count_rises(rc, mc, ec, tc, xc);
    chk("hdx_txc", mc, tc);
    chk("hdx_rxc", 32'h0, xc);
    chk("hdx_rxlvl", 1'h0, rxc);
    @(posedge clk);
    {run, hdx, step} <= 3'h1;
    idle(2);
    chk("step_hi", 1'h1, txc);
    @(posedge clk);
    step <= 1'h0;
    idle(2);
    chk("step_lo", 1'h0, txc);
    $display("t_clk done");
  endtask : t_clk

  // ----------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'h1, 47'h0};
    {dsr, cts, ring, ctsn, rxd, skew, lreq, rfq, run, hdx, txd, step} = 12'h100;
    trn = 1'h1;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    idle(4);
    t_regs;
    t_status;
    t_modes;
    t_straps;
    t_clk;
    report_and_stop;
  end

  // the whole sequence needs a few thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop;
  end
endmodule : tb_top
